// ==== dv/mhbi_bench.sv ====
/*
 * Bench joining both ends: AHB-Lite and DMA drivers, result queue, monitor.
 * Assumes the hand-over timing of both ends and a 125 MHz hclk.
 */
`default_nettype none
module mhbi_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import mhbi_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic rd_ph = 1'b0, dma_rd = 1'b0, dma_req = 1'b0, dma_write = 1'b0;
    logic [1:0] htrans = 2'h0, dma_bmask = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [15:0] dma_addr = 16'h0, dma_wdata = 16'h0, dma_rdata;
    logic [15:0] base, wd, ad, exp_v;
    logic [4:0] flag_evt = 5'h00, flags;
    logic hreadyout, hresp, dma_busy, dma_done;
    logic [15:0] exp_q[$];
    int error_cnt = 0, n_checks = 0, k;
    always #4 hclk = ~hclk;
    mhbi_if bus();
    mhbi_dev_end u_mhbi_dev_end(.hclk(hclk), .hresetn(hresetn), .pins(bus),
        .dma_req(dma_req), .dma_write(dma_write), .dma_addr(dma_addr),
        .dma_wdata(dma_wdata), .dma_bmask(dma_bmask), .flag_evt(flag_evt),
        .dma_busy(dma_busy), .dma_done(dma_done), .dma_rdata(dma_rdata),
        .flags(flags));
    mhbi_host_end u_mhbi_host_end(.hclk(hclk), .hresetn(hresetn),
        .pins(bus), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
    mhbi_checker u_mhbi_checker(.hclk(hclk), .hresetn(hresetn),
        .bus_dev_oe(bus.bus_dev_oe), .bus_host_oe(bus.bus_host_oe),
        .dir_dev_oe(bus.dir_dev_oe), .das_dev_oe(bus.das_dev_oe),
        .as_oe(bus.as_oe), .xcvr_inbound_ctl_oe(bus.xcvr_inbound_ctl_oe), .xcvr_outbound_ctl_oe(bus.xcvr_outbound_ctl_oe),
        .bm_lo_oe(bus.bm_lo_oe), .bm_hi_oe(bus.bm_hi_oe),
        .xfer_dir(bus.xfer_dir), .data_phase_strobe(bus.data_phase_strobe),
        .xcvr_inbound_ctl(bus.xcvr_inbound_ctl),
        .xcvr_outbound_ctl(bus.xcvr_outbound_ctl),
        .bus_req_n(bus.bus_req_n), .bus_grant_in(bus.bus_grant_in));
    // -------------------------------------------------------------
    // drivers and checking
    // -------------------------------------------------------------
    task check(input logic [15:0] got, input logic [15:0] want);
        n_checks++;
        if (got !== want) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, want);
        end
    endtask
    task results;
        if (error_cnt == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task ahb(input logic w, input logic [4:0] a, input logic [15:0] d,
             input logic c, input logic [15:0] e);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {27'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        if (c) exp_q.push_back(e);
        htrans <= 2'h0;
        hwdata <= {16'h0, d};
        rd_ph <= !w && c;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        rd_ph <= 1'b0;
    endtask
    // slave cycle to a device register, then wait for it to finish
    task slv(input logic w, input logic i, input logic [15:0] d);
        ahb(1'b1, A_WDATA, d, 1'b0, 16'h0);
        ahb(1'b1, A_CTRL, {9'h000, 2'b01, 2'b00, i, w, 1'b1}, 1'b0, 16'h0);
        repeat (20) begin
            ahb(1'b0, A_STATUS, 16'h0, 1'b0, 16'h0);
            if (rd[0] === 1'b0) break;
        end
    endtask
    task dma(input logic w, input logic [15:0] a, input logic [15:0] d,
             input logic [1:0] m, input logic [15:0] e);
        @(posedge hclk);
        dma_req <= 1'b1;
        dma_write <= w;
        dma_addr <= a;
        dma_wdata <= d;
        dma_bmask <= m;
        dma_rd <= !w;
        if (!w) exp_q.push_back(e);
        @(posedge hclk);
        dma_req <= 1'b0;
        while (dma_done !== 1'b1) @(posedge hclk);
        check(16'(dma_busy), 16'h0000);
    endtask
    task pulse(input int b);
        @(posedge hclk);
        flag_evt <= 5'(1 << b);
        @(posedge hclk);
        flag_evt <= 5'h00;
    endtask
    always @(posedge hclk) begin
        if ((dma_done === 1'b1 && dma_rd) || rd_ph)
            check(rd_ph ? hrdata[15:0] : dma_rdata, exp_q.pop_front());
    end
    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        results();
    end
    initial begin
        k = $urandom(64308);
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b1, A_CTRL, 16'h0020, 1'b0, 16'h0);
        ahb(1'b0, 5'h18, 16'h0, 1'b1, 16'h0000);
        for (int m = 0; m < 4; m++) begin
            base = 16'($urandom);
            wd = 16'($urandom);
            ad = 16'($urandom);
            ad[3:0] = 4'(m);
            exp_v = m == 0 ? wd : m == 1 ? {wd[15:8], base[7:0]} :
                    m == 2 ? {base[15:8], wd[7:0]} : base;
            ahb(1'b1, A_MEMIDX, 16'(m), 1'b0, 16'h0);
            ahb(1'b1, A_MEMDATA, base, 1'b0, 16'h0);
            dma(1'b1, ad, wd, 2'(m), 16'h0);
            ahb(1'b0, A_MEMDATA, 16'h0, 1'b1, exp_v);
            dma(1'b0, ad, 16'h0, 2'h0, exp_v);
        end
        k = $urandom_range(4, 0);
        slv(1'b1, REG_IDX_MAIN, 16'h0040);
        pulse(k);
        ahb(1'b0, A_STATUS, 16'h0, 1'b1, 16'h0008);
        check(16'(flags), 16'(1 << k));
        slv(1'b0, REG_IDX_MAIN, 16'h0000);
        ahb(1'b0, A_RDATA, 16'h0, 1'b1, 16'h0040 | 16'(1 << (k + 8)));
        slv(1'b1, REG_IDX_MAIN, 16'h1F00);
        pulse(k);
        ahb(1'b0, A_STATUS, 16'h0, 1'b1, 16'h0000);
        slv(1'b1, REG_IDX_CFG, 16'h0002);
        ahb(1'b1, A_CTRL, 16'h0060, 1'b0, 16'h0);
        dma(1'b1, ad, wd, 2'h0, 16'h0);
        dma(1'b0, ad, 16'h0, 2'h0, wd);
        results();
    end
endmodule
`default_nettype wire

// ==== dv/mhbi_checker.sv ====
/*
 * Pin-level assertions for the multiplexed host bus, beside the interface.
 * Assumes the interface signals and the single hclk domain.
 */
`default_nettype none
module mhbi_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic bus_dev_oe,
    input wire logic bus_host_oe,
    input wire logic dir_dev_oe,
    input wire logic das_dev_oe,
    input wire logic as_oe,
    input wire logic xcvr_inbound_ctl_oe,
    input wire logic xcvr_outbound_ctl_oe,
    input wire logic bm_lo_oe,
    input wire logic bm_hi_oe,
    input wire logic xfer_dir,
    input wire logic data_phase_strobe,
    input wire logic xcvr_inbound_ctl,
    input wire logic xcvr_outbound_ctl,
    input wire logic bus_req_n,
    input wire logic bus_grant_in
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // -------------------------------------------------------------
    // master transfer steps
    // -------------------------------------------------------------
    sequence s_start;
        $rose(dir_dev_oe);
    endsequence
    sequence s_wdata;
        das_dev_oe && !data_phase_strobe && !xfer_dir;
    endsequence
    no_contention_a: assert property (!(bus_dev_oe && bus_host_oe))
        else $error("both ends drive the bus");
    master_pins_a: assert property ((das_dev_oe || as_oe || xcvr_inbound_ctl_oe ||
        xcvr_outbound_ctl_oe || bm_lo_oe || bm_hi_oe) |-> dir_dev_oe)
        else $error("master pin driven while not master");
    inbound_read_a: assert property (xcvr_inbound_ctl |->
        dir_dev_oe && xfer_dir && !data_phase_strobe)
        else $error("inbound control outside read data phase");
    outbound_write_a: assert property (s_wdata |->
        xcvr_outbound_ctl && bus_dev_oe && !xcvr_inbound_ctl)
        else $error("write data phase without outbound drive");
    slave_drive_a: assert property (bus_dev_oe && !dir_dev_oe |-> xfer_dir)
        else $error("slave drives bus on a write");
    req_idle_a: assert property ($fell(bus_req_n) |-> !$past(bus_grant_in))
        else $error("request raised while grant active");
    read_turn_a: assert property (s_start and xfer_dir |->
        xcvr_outbound_ctl ##1 !bus_dev_oe ##1 xcvr_inbound_ctl)
        else $error("read address, turn, data order broken");
    write_data_a: assert property (s_start and !xfer_dir |->
        as_oe && bus_dev_oe ##1 s_wdata)
        else $error("write data phase does not follow address");
endmodule
`default_nettype wire

// ==== rtl/mhbi_dev_end.sv ====
/*
 * Device end: DMA bus master and register slave on the multiplexed
 * address/data bus, with the open-drain attention line.
 * Assumes the host end keeps chip select high while it grants the bus.
 */
// The AHB-Lite interface to the registers and the address map were decided locally.
// Behaviour
// - address phase carries low 16 address bits
// - data phase carries read or write word
// - direction driven only as master, whole transaction
// - slave: drive when direction high, capture low
// - master read: capture memory word in data
// - interrupt when any flag set and enabled
// - inbound control only in read data phase
// - outbound control on read address, whole write
// - strobe marks data phase, valid at rise
// - config bit 6 set: release ends burst
// - config bit 6 clear: pin is byte mask
// - mask encoding per lane, master only
// - request when grant idle, hold through transaction
// - address strobe with selectable polarity, master only
`default_nettype none
module mhbi_dev_end (
    input wire logic hclk,
    input wire logic hresetn,
    mhbi_if.dev pins,
    input wire logic dma_req,
    input wire logic dma_write,
    input wire logic [mhbi_pkg::DW-1:0] dma_addr,
    input wire logic [mhbi_pkg::DW-1:0] dma_wdata,
    input wire logic [1:0] dma_bmask,
    input wire logic [mhbi_pkg::NFLAG-1:0] flag_evt,
    output logic dma_busy,
    output logic dma_done,
    output logic [mhbi_pkg::DW-1:0] dma_rdata,
    output logic [mhbi_pkg::NFLAG-1:0] flags
);
    import mhbi_pkg::*;

    mhbi_dst_e st_q, st_d;
    logic wr_q, wr_d;
    logic [DW-1:0] addr_q, addr_d, wdat_q, wdat_d, rdat_q, rdat_d;
    logic [1:0] bm_q, bm_d;
    logic [NFLAG-1:0] flag_q, flag_d;
    logic ien_q, ien_d;
    logic [DW-1:0] cfg_q, cfg_d;
    logic rel_q, rel_d;
    logic slv_q, slv_d, idx_q, idx_d;
    logic [DW-1:0] bus_o_q, bus_o_d;
    logic bus_oe_q, bus_oe_d, mst_q, mst_d, dir_q, dir_d;
    logic das_q, das_d, as_q, as_d, xcvr_inbound_ctl_q, xcvr_inbound_ctl_d, xcvr_outbound_ctl_q, xcvr_outbound_ctl_d;
    logic lo_oe_q, lo_oe_d, breq_q, breq_d, irq_q, irq_d;
    logic busy_q, busy_d, done_q, done_d;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic rel_now, take, leave_own, sel, slv_rd, slv_wr;
    logic wr_main, wr_cfg, d_addr, d_wdat, d_rdat;
    logic [DW-1:0] bus, main_word, rd_word, clr_mask;
    assign bus = pins.mux_addr_data_bus;
    assign rel_now = cfg_q[CFG_REL_BIT] & pins.bm_lo_rel_pin;
    assign take = dma_req & (st_q == DS_IDLE || st_q == DS_OWN);
    assign leave_own = (st_q == DS_OWN) && (st_d == DS_REQ);
    assign d_addr = (st_d == DS_ADDR);
    assign d_wdat = (st_d == DS_WDATA);
    assign d_rdat = (st_d == DS_RDATA);
    assign sel = !pins.chip_sel_n && !mst_q;
    assign slv_rd = sel && pins.xfer_dir;
    assign slv_wr = sel && slv_q && !pins.xfer_dir &&
                    !pins.data_phase_strobe;
    assign wr_main = slv_wr && (idx_q == REG_IDX_MAIN);
    assign wr_cfg = slv_wr && (idx_q == REG_IDX_CFG);
    assign clr_mask = wr_main ? bus : '0;
    assign main_word = ({{(DW-NFLAG){1'b0}}, flag_q} << MAIN_FLAG_LSB) |
                       ({{(DW-1){1'b0}}, ien_q} << MAIN_IEN_BIT);
    assign rd_word = idx_d ? cfg_q : main_word;

    // ------------------------------------------------------------
    // master sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        case (st_q)
            DS_IDLE: begin
                if (dma_req) begin
                    st_d = DS_REQ;
                end
            end
            DS_REQ: begin
                if (breq_q && pins.bus_grant_in) begin
                    st_d = DS_ADDR;
                end
            end
            DS_ADDR: st_d = wr_q ? DS_WDATA : DS_TURN;
            DS_TURN: st_d = DS_RDATA;
            DS_RDATA: st_d = DS_OWN;
            DS_WDATA: st_d = DS_OWN;
            DS_OWN: begin
                if (dma_req && !(rel_q || rel_now)) begin
                    st_d = DS_ADDR;
                end else if (dma_req) begin
                    st_d = DS_REQ;
                end else begin
                    st_d = DS_IDLE;
                end
            end
            default: st_d = DS_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // next values of pins and state
    // ------------------------------------------------------------
    assign wr_d = take ? dma_write : wr_q;
    assign addr_d = take ? dma_addr : addr_q;
    assign wdat_d = take ? dma_wdata : wdat_q;
    assign bm_d = take ? dma_bmask : bm_q;
    assign mst_d = !(st_d == DS_IDLE || st_d == DS_REQ);
    // bus released while idle, re-requested only after grant drops
    assign breq_d = (st_d != DS_IDLE) && !leave_own &&
                    (breq_q || !pins.bus_grant_in);
    assign rel_d = (mst_d && st_q != DS_OWN) ? (rel_q | rel_now) : 1'b0;
    assign bus_oe_d = d_addr || d_wdat || slv_rd;
    assign bus_o_d = slv_rd ? rd_word :
                     d_addr ? addr_d : wdat_d;
    assign dir_d = mst_d ? !wr_d : dir_q;
    assign das_d = !(d_rdat || d_wdat);
    assign as_d = d_addr ^ cfg_q[CFG_ADDR_STROBE_POLARITY_BIT_BIT];
    assign xcvr_inbound_ctl_d = d_rdat;
    assign xcvr_outbound_ctl_d = d_addr || d_wdat;
    assign lo_oe_d = mst_d && !cfg_q[CFG_REL_BIT];
    assign rdat_d = (st_q == DS_RDATA) ? bus : rdat_q;
    assign busy_d = !(st_d == DS_IDLE || st_d == DS_OWN);
    assign done_d = (st_q == DS_RDATA) || (st_q == DS_WDATA);
    assign slv_d = sel;
    assign idx_d = (sel && !slv_q) ? bus[0] : idx_q;
    assign flag_d = (flag_q & ~clr_mask[MAIN_FLAG_LSB +: NFLAG]) | flag_evt;
    assign ien_d = wr_main ? bus[MAIN_IEN_BIT] : ien_q;
    assign cfg_d = wr_cfg ? (bus & CFG_MASK) : cfg_q;
    assign irq_d = ien_d && (|flag_d);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= DS_IDLE;
            wr_q <= 1'b0;
            addr_q <= '0;
            wdat_q <= '0;
            bm_q <= 2'h0;
            rel_q <= 1'b0;
            rdat_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            wr_q <= wr_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            bm_q <= bm_d;
            rel_q <= rel_d;
            rdat_q <= rdat_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_q <= FLAG_RST;
            ien_q <= 1'b0;
            cfg_q <= CFG_RST;
            slv_q <= 1'b0;
            idx_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            ien_q <= ien_d;
            cfg_q <= cfg_d;
            slv_q <= slv_d;
            idx_q <= idx_d;
            irq_q <= irq_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_o_q <= '0;
            bus_oe_q <= 1'b0;
            mst_q <= 1'b0;
            dir_q <= 1'b1;
            das_q <= 1'b1;
            as_q <= 1'b0;
            xcvr_inbound_ctl_q <= 1'b0;
            xcvr_outbound_ctl_q <= 1'b0;
            lo_oe_q <= 1'b0;
            breq_q <= 1'b0;
        end else begin
            bus_o_q <= bus_o_d;
            bus_oe_q <= bus_oe_d;
            mst_q <= mst_d;
            dir_q <= dir_d;
            das_q <= das_d;
            as_q <= as_d;
            xcvr_inbound_ctl_q <= xcvr_inbound_ctl_d;
            xcvr_outbound_ctl_q <= xcvr_outbound_ctl_d;
            lo_oe_q <= lo_oe_d;
            breq_q <= breq_d;
        end
    end

    // ------------------------------------------------------------
    // pins and user side
    // ------------------------------------------------------------
    assign pins.bus_dev_o = bus_o_q;
    assign pins.bus_dev_oe = bus_oe_q;
    assign pins.dir_dev_o = dir_q;
    assign pins.dir_dev_oe = mst_q;
    assign pins.das_dev_o = das_q;
    assign pins.das_dev_oe = mst_q;
    assign pins.as_o = as_q;
    assign pins.as_oe = mst_q;
    assign pins.xcvr_inbound_ctl_o = xcvr_inbound_ctl_q;
    assign pins.xcvr_inbound_ctl_oe = mst_q;
    assign pins.xcvr_outbound_ctl_o = xcvr_outbound_ctl_q;
    assign pins.xcvr_outbound_ctl_oe = mst_q;
    assign pins.bm_lo_o = bm_q[0];
    assign pins.bm_lo_oe = lo_oe_q;
    assign pins.bm_hi_o = bm_q[1];
    assign pins.bm_hi_oe = mst_q;
    assign pins.irq_oe = irq_q;
    assign pins.breq_oe = breq_q;
    assign dma_busy = busy_q;
    assign dma_done = done_q;
    assign dma_rdata = rdat_q;
    assign flags = flag_q;
endmodule
`default_nettype wire

// ==== rtl/mhbi_host_end.sv ====
/*
 * Host end: bus arbiter, word memory answering device DMA, and a slave
 * access engine reaching the device registers, all steered over AHB-Lite.
 * Assumes single word transfers only; hsize is not checked.
 */
`default_nettype none
module mhbi_host_end (
    input wire logic hclk,
    input wire logic hresetn,
    mhbi_if.host pins,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    import mhbi_pkg::*;

    mhbi_hst_e st_q, st_d;
    logic ap_q, ap_wr_q;
    logic [4:0] ap_a_q;
    logic [6:0] ctrl_q, ctrl_d;
    logic [DW-1:0] wdat_q, rdat_q, bus_o_q, bus_o_d, mword, aword;
    logic [MEM_AW-1:0] midx_q, maddr_q, maddr_d;
    logic [31:0] hrdata_q, rd_mux;
    logic pend_q, pend_d, grant_q, grant_d, moe_q, moe_d, oe_q, oe_d;
    logic cs_n_q, dir_oe_q, das_q;

    // ------------------------------------------------------------
    // AHB-Lite slave decode
    // ------------------------------------------------------------
    logic ap_take, we, go_wr, busy, start, as_act, m_we, e_rd;
    logic [1:0] lane_en;
    assign ap_take = hsel && hready && htrans[1];
    assign we = ap_q && ap_wr_q;
    assign busy = pend_q || (st_q != HS_IDLE);
    assign go_wr = we && (ap_a_q == A_CTRL) && hwdata[CTRL_GO];
    assign start = pend_q && (st_q == HS_IDLE) && !grant_q;
    assign ctrl_d = (we && ap_a_q == A_CTRL) ?
                    {hwdata[6:1], 1'b0} : ctrl_q;
    assign pend_d = (pend_q && !start) || (go_wr && !busy);

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr[4:0])
            A_CTRL: rd_mux = {25'h0, ctrl_q};
            A_WDATA: rd_mux = {16'h0, wdat_q};
            A_RDATA: rd_mux = {16'h0, rdat_q};
            A_STATUS: rd_mux = {28'h0, !pins.irq_out_n, !pins.bus_req_n,
                                grant_q, busy};
            A_MEMIDX: rd_mux = {28'h0, midx_q};
            A_MEMDATA: rd_mux = {16'h0, aword};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_q <= 1'b0;
            ap_wr_q <= 1'b0;
            ap_a_q <= 5'h00;
            hrdata_q <= 32'h0000_0000;
            ctrl_q <= CTRL_RST;
            wdat_q <= '0;
            midx_q <= '0;
        end else begin
            ap_q <= ap_take;
            ap_wr_q <= hwrite;
            ap_a_q <= haddr[4:0];
            hrdata_q <= (ap_take && !hwrite) ? rd_mux : hrdata_q;
            ctrl_q <= ctrl_d;
            wdat_q <= (we && ap_a_q == A_WDATA) ? hwdata[DW-1:0] : wdat_q;
            midx_q <= (we && ap_a_q == A_MEMIDX) ?
                      hwdata[MEM_AW-1:0] : midx_q;
        end
    end

    // ------------------------------------------------------------
    // slave access engine
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        case (st_q)
            HS_IDLE: begin
                if (start) begin
                    st_d = HS_ADDR;
                end
            end
            HS_ADDR: st_d = ctrl_q[CTRL_WR] ? HS_DATA : HS_TURN;
            HS_TURN: st_d = HS_DATA;
            HS_DATA: st_d = HS_END;
            HS_END: st_d = HS_IDLE;
            default: st_d = HS_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // arbiter and memory responder
    // ------------------------------------------------------------
    assign grant_d = ctrl_q[CTRL_GNT_EN] && !pins.bus_req_n &&
                     (grant_q || (st_q == HS_IDLE && !pend_q));
    // floated strobe reads active in one polarity: qualify by outbound
    assign as_act = grant_q && pins.xcvr_outbound_ctl &&
                    (pins.addr_strobe_n ^ ctrl_q[CTRL_ASPOL]);
    assign maddr_d = as_act ? pins.mux_addr_data_bus[MEM_AW-1:0] :
                     maddr_q;
    // hold read data until the strobe is seen low
    assign moe_d = (as_act && pins.xfer_dir) ||
                   (moe_q && pins.data_phase_strobe);
    assign m_we = grant_q && !pins.xfer_dir && !pins.data_phase_strobe;
    assign lane_en[0] = ctrl_q[CTRL_REL_DRV] || !pins.bm_lo_rel_pin;
    assign lane_en[1] = !pins.byte_mask_hi;
    assign e_rd = (st_d == HS_TURN) || (st_d == HS_DATA);
    assign oe_d = moe_d || (st_d == HS_ADDR) ||
                  (st_d == HS_DATA && ctrl_q[CTRL_WR]);
    assign bus_o_d = moe_d ? mword :
                     (st_d == HS_ADDR) ? {15'h0000, ctrl_q[CTRL_IDX]} :
                     wdat_q;

    for (genvar l = 0; l < 2; l++) begin : g_lane
        logic [7:0] m_q [MEM_DEPTH];
        always_ff @(posedge hclk) begin
            if (m_we && lane_en[l]) begin
                m_q[maddr_q] <= pins.mux_addr_data_bus[l*8 +: 8];
            end else if (we && ap_a_q == A_MEMDATA) begin
                m_q[midx_q] <= hwdata[l*8 +: 8];
            end
        end
        assign mword[l*8 +: 8] = m_q[maddr_d];
        assign aword[l*8 +: 8] = m_q[midx_q];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= HS_IDLE;
            pend_q <= 1'b0;
            grant_q <= 1'b0;
            maddr_q <= '0;
            moe_q <= 1'b0;
            oe_q <= 1'b0;
            bus_o_q <= '0;
            rdat_q <= '0;
        end else begin
            st_q <= st_d;
            pend_q <= pend_d;
            grant_q <= grant_d;
            maddr_q <= maddr_d;
            moe_q <= moe_d;
            oe_q <= oe_d;
            bus_o_q <= bus_o_d;
            rdat_q <= (st_q == HS_DATA && !ctrl_q[CTRL_WR]) ?
                      pins.mux_addr_data_bus : rdat_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cs_n_q <= 1'b1;
            dir_oe_q <= 1'b0;
            das_q <= 1'b1;
        end else begin
            cs_n_q <= !(st_d == HS_ADDR || e_rd);
            dir_oe_q <= (st_d == HS_ADDR) || e_rd;
            das_q <= (st_d != HS_DATA);
        end
    end

    assign pins.bus_host_o = bus_o_q;
    assign pins.bus_host_oe = oe_q;
    assign pins.dir_host_o = !ctrl_q[CTRL_WR];
    assign pins.dir_host_oe = dir_oe_q;
    assign pins.das_host_o = das_q;
    assign pins.das_host_oe = dir_oe_q;
    assign pins.rel_o = ctrl_q[CTRL_REL_LVL];
    assign pins.rel_oe = ctrl_q[CTRL_REL_DRV];
    assign pins.bus_grant_in = grant_q;
    assign pins.chip_sel_n = cs_n_q;
    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule
`default_nettype wire

// ==== rtl/mhbi_if.sv ====
/*
 * Pin bundle between the device end and the host end.
 * Each shared pin is resolved here from the drivers' enables; undriven
 * pins float to their pull level.
 */
`default_nettype none
interface mhbi_if;
    logic [15:0] bus_dev_o, bus_host_o, mux_addr_data_bus;
    logic bus_dev_oe, bus_host_oe;
    logic dir_dev_o, dir_dev_oe, dir_host_o, dir_host_oe, xfer_dir;
    logic das_dev_o, das_dev_oe, das_host_o, das_host_oe, data_phase_strobe;
    logic bm_lo_o, bm_lo_oe, rel_o, rel_oe, bm_lo_rel_pin;
    logic bm_hi_o, bm_hi_oe, byte_mask_hi;
    logic as_o, as_oe, addr_strobe_n;
    logic xcvr_inbound_ctl_o, xcvr_inbound_ctl_oe, xcvr_inbound_ctl;
    logic xcvr_outbound_ctl_o, xcvr_outbound_ctl_oe, xcvr_outbound_ctl;
    logic irq_oe, irq_out_n;
    logic breq_oe, bus_req_n;
    logic bus_grant_in, chip_sel_n;

    assign mux_addr_data_bus = bus_dev_oe ? bus_dev_o :
                               bus_host_oe ? bus_host_o : 16'hFFFF;
    assign xfer_dir = dir_dev_oe ? dir_dev_o :
                      dir_host_oe ? dir_host_o : 1'b1;
    assign data_phase_strobe = das_dev_oe ? das_dev_o :
                               das_host_oe ? das_host_o : 1'b1;
    assign bm_lo_rel_pin = bm_lo_oe ? bm_lo_o : rel_oe ? rel_o : 1'b0;
    assign byte_mask_hi = bm_hi_oe ? bm_hi_o : 1'b1;
    assign addr_strobe_n = as_oe ? as_o : 1'b1;
    assign xcvr_inbound_ctl = xcvr_inbound_ctl_oe ? xcvr_inbound_ctl_o : 1'b0;
    assign xcvr_outbound_ctl = xcvr_outbound_ctl_oe ? xcvr_outbound_ctl_o : 1'b0;
    assign irq_out_n = irq_oe ? 1'b0 : 1'b1;
    assign bus_req_n = breq_oe ? 1'b0 : 1'b1;

    modport dev (
        output bus_dev_o, bus_dev_oe, dir_dev_o, dir_dev_oe,
        output das_dev_o, das_dev_oe, bm_lo_o, bm_lo_oe, bm_hi_o, bm_hi_oe,
        output as_o, as_oe, xcvr_inbound_ctl_o, xcvr_inbound_ctl_oe, xcvr_outbound_ctl_o, xcvr_outbound_ctl_oe,
        output irq_oe, breq_oe,
        input mux_addr_data_bus, xfer_dir, data_phase_strobe, bm_lo_rel_pin,
        input bus_grant_in, chip_sel_n
    );
    modport host (
        output bus_host_o, bus_host_oe, dir_host_o, dir_host_oe,
        output das_host_o, das_host_oe, rel_o, rel_oe,
        output bus_grant_in, chip_sel_n,
        input mux_addr_data_bus, xfer_dir, data_phase_strobe, bm_lo_rel_pin,
        input byte_mask_hi, addr_strobe_n, irq_out_n, bus_req_n,
        input xcvr_outbound_ctl
    );
endinterface
`default_nettype wire

// ==== rtl/mhbi_pkg.sv ====
/*
 * Constants, register layouts and state types shared by both ends of the
 * multiplexed host bus interface.
 * Assumes a single 125 MHz clock domain on both ends.
 */
`default_nettype none
package mhbi_pkg;
    localparam int DW = 16;
    localparam int NFLAG = 5;
    localparam int MEM_AW = 4;
    localparam int MEM_DEPTH = 16;
    localparam logic [DW-1:0] BUS_FLOAT = 16'hFFFF;
    // device side registers, selected by address bit 0 in a slave cycle
    localparam logic REG_IDX_MAIN = 1'b0;
    localparam logic REG_IDX_CFG = 1'b1;
    localparam int MAIN_FLAG_LSB = 8;
    localparam int MAIN_IEN_BIT = 6;
    localparam int CFG_BYTE_CTL_SELECT_BIT_BIT = 0;
    localparam int CFG_ADDR_STROBE_POLARITY_BIT_BIT = 1;
    localparam int CFG_REL_BIT = 6;
    localparam logic [DW-1:0] CFG_MASK = 16'h0043;
    localparam logic [NFLAG-1:0] FLAG_RST = 5'h00;
    localparam logic [DW-1:0] CFG_RST = 16'h0000;
    // controller registers on AHB-Lite
    localparam logic [4:0] A_CTRL = 5'h00;
    localparam logic [4:0] A_WDATA = 5'h04;
    localparam logic [4:0] A_RDATA = 5'h08;
    localparam logic [4:0] A_STATUS = 5'h0C;
    localparam logic [4:0] A_MEMIDX = 5'h10;
    localparam logic [4:0] A_MEMDATA = 5'h14;
    localparam int CTRL_GO = 0;
    localparam int CTRL_WR = 1;
    localparam int CTRL_IDX = 2;
    localparam int CTRL_REL_LVL = 3;
    localparam int CTRL_REL_DRV = 4;
    localparam int CTRL_GNT_EN = 5;
    localparam int CTRL_ASPOL = 6;
    localparam logic [6:0] CTRL_RST = 7'h00;

    typedef enum logic [6:0] {
        DS_IDLE = 7'h01,
        DS_REQ = 7'h02,
        DS_ADDR = 7'h04,
        DS_TURN = 7'h08,
        DS_RDATA = 7'h10,
        DS_WDATA = 7'h20,
        DS_OWN = 7'h40
    } mhbi_dst_e;

    typedef enum logic [4:0] {
        HS_IDLE = 5'h01,
        HS_ADDR = 5'h02,
        HS_TURN = 5'h04,
        HS_DATA = 5'h08,
        HS_END = 5'h10
    } mhbi_hst_e;
endpackage
`default_nettype wire
